// ===== umcls_pkg.sv
// Constants for the modem-control and line-status block.
// Assumes a single 125 MHz host clock and a synchronous reset.
package umcls_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam int ADDR_W = 4;
    localparam logic [3:0] OFS_FIFO_IDENT = 4'h2;
    localparam logic [3:0] OFS_MODEM_CONTROL = 4'h4;
    localparam logic [3:0] OFS_LINE_STATUS = 4'h5;
    localparam logic [3:0] OFS_IRQ_STATUS = 4'h8;
    localparam logic [3:0] OFS_IRQ_MASK = 4'h9;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int MC_DTR = 0;
    localparam int MC_RTS = 1;
    localparam int MC_AUX_A = 2;
    localparam int MC_AUX_B = 3;
    localparam int MC_LOOP = 4;
    localparam int FC_ENABLE = 0;
    localparam int EV_HOLD_EMPTY = 0;
    localparam int EV_RX_ERR = 1;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [4:0] MC_RESET = 5'h00;
    localparam logic LS_HOLD_EMPTY_RESET = 1'b1;
    localparam logic LS_TEMT_RESET = 1'b1;
    localparam logic LS_RX_ERR_RESET = 1'b0;
    localparam logic [1:0] IRQ_STS_RESET = 2'h0;
    localparam logic [1:0] IRQ_MSK_RESET = 2'h0;

    // Ident code field: 010 holding-empty pending, 001 nothing pending
    localparam logic [2:0] IDENT_NONE = 3'h1;
    localparam logic [2:0] IDENT_HOLD_EMPTY = 3'h2;

    localparam int SYNC_W = 5;

endpackage : umcls_pkg

// ===== umcls_sync.sv
// Two-flop synchroniser for the modem and serial receive pins.
// Assumes the pins are asynchronous to ref_clk.
`timescale 1ns/1ps
`default_nettype none
module umcls_sync #(
    parameter int W = 5
) (
    input wire logic ref_clk,          // Host clock
    input wire logic reset,            // Synchronous, active high
    input wire logic [W-1:0] async_in, // Raw pins
    output logic [W-1:0] sync_out      // Synchronised pins
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } umcls_sync_st_t;

    umcls_sync_st_t st_r;
    umcls_sync_st_t st_nxt;

    // Pins idle high; reset to that level to avoid false edges
    always_comb begin
        st_nxt.s1 = async_in;
        st_nxt.s2 = st_r.s1;
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            st_r <= '1;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign sync_out = st_r.s2;
endmodule : umcls_sync
`default_nettype wire

// ===== umcls_top.sv
// Modem control, loopback, upper line status and interrupt gating.
// Assumes transmit/receive shift logic and FIFOs on the same clock.
//
// Function
// [RULE1] Loopback holds the serial transmit pin high (marking).
// [RULE2] Loopback feeds transmit shift output straight into the receiver.
// [RULE3] Loopback ignores the four external modem handshake inputs.
// [RULE4] Loopback routes modem outputs to inputs and drives output pins high.
// [RULE5] Port interrupt reaches the output only while aux out b is one.
// [RULE6] Aux out a is plain read/write storage without a pin.
// [RULE7] Outside loopback the request-to-send pin is inverse of its bit.
// [RULE8] Outside loopback the terminal-ready pin is inverse of its bit.
// [RULE9] Without FIFOs the receiver FIFO error bit reads zero.
// [RULE10] In FIFO mode an errored character in the FIFO sets the error bit.
// [RULE11] Line status read clears the error bit unless errors remain.
// [RULE12] Transmitter empty is one when holding and shift registers are empty.
// [RULE13] Non-FIFO: holding empty sets when character moves to shift register.
// [RULE14] Holding empty raises transmit interrupt; ident read clears it.
// [RULE15] FIFO mode: holding empty sets on FIFO empty, clears on write.
// [RULE16] FIFO mode follows the enable bit; clearing it flushes both FIFOs.
// [RULE17] Loopback modem status mirrors the internal control bits.
// [RULE18] Modem control bits 7 to 5 ignore writes and read zero.
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module umcls_top
    import umcls_pkg::*;
(
    input wire logic ref_clk,             // 125 MHz host clock
    input wire logic reset,               // Synchronous, active high
    input wire logic [ADDR_W-1:0] addr,   // Register address
    input wire logic [7:0] wdata,         // Write data
    input wire logic wr,                  // Write strobe
    input wire logic rd,                  // Read strobe
    output logic [7:0] rdata,             // Read data, cycle after rd
    input wire logic tx_shift_out,        // Transmit shift register bit
    input wire logic tx_shift_empty,      // Transmit shift register idle
    input wire logic tx_load,             // Held char moved to shift reg
    input wire logic tx_write,            // Byte written to holding/FIFO
    input wire logic tx_fifo_empty,       // Transmit FIFO empty level
    input wire logic rx_err_push,         // Errored char entered rx FIFO
    input wire logic rx_err_remain,       // Errored chars still in FIFO
    input wire logic [4:0] ls_low,        // Lower line status bits
    input wire logic port_irq_in,         // Other serial interrupt sources
    input wire logic serial_rx_pin,       // Receive pin
    input wire logic cts_n,               // Clear-to-send pin
    input wire logic dsr_n,               // Data-set-ready pin
    input wire logic ring_indicator_n,    // Ring pin
    input wire logic carrier_detect_n,    // Carrier detect pin
    output logic serial_tx_pin,           // Transmit pin
    output logic rts_n,                   // Request-to-send pin
    output logic dtr_n,                   // Terminal-ready pin
    output logic rx_serial_in,            // To receive shift register
    output logic [3:0] modem_status,      // {carrier, ring, dsr, cts}, true level
    output logic fifo_mode,               // FIFOs enabled
    output logic fifo_flush,              // Pulse: empty both FIFOs
    output logic hold_empty_irq,          // Priority-3 transmit pending
    output logic irq                      // Gated interrupt output
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [4:0] mc;
        logic fifo_en;
        logic rx_err;
        logic temt;
        logic hold_empty;
        logic hold_pend;
        logic txf_empty_q;
        logic [1:0] sts;
        logic [1:0] msk;
        logic [7:0] rdata;
        logic tx_pin;
        logic rx_in;
        logic dtr_n;
        logic rts_n;
        logic [3:0] msl;
        logic irq;
        logic flush;
    } umcls_state_t;

    umcls_state_t st_r;
    umcls_state_t st_nxt;
    logic [SYNC_W-1:0] pins_s;

    umcls_sync #(
        .W(SYNC_W)
    ) u_sync (
        .ref_clk(ref_clk),
        .reset(reset),
        .async_in({carrier_detect_n, ring_indicator_n, dsr_n, cts_n, serial_rx_pin}),
        .sync_out(pins_s)
    );

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    logic wr_mc;
    logic wr_fc;
    logic wr_sts;
    logic wr_msk;
    logic rd_ls;
    logic rd_ident;
    logic loop_nxt;
    logic hold_set;
    logic [1:0] ev;

    always_comb begin
        wr_mc = wr && (addr == OFS_MODEM_CONTROL);
        wr_fc = wr && (addr == OFS_FIFO_IDENT);
        wr_sts = wr && (addr == OFS_IRQ_STATUS);
        wr_msk = wr && (addr == OFS_IRQ_MASK);
        rd_ls = rd && (addr == OFS_LINE_STATUS);
        rd_ident = rd && (addr == OFS_FIFO_IDENT);
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        // Aux out a is stored only, no pin
        if (wr_mc) begin
            st_nxt.mc = wdata[4:0]; // [RULE6] [RULE18]
        end
        if (wr_fc) begin
            st_nxt.fifo_en = wdata[FC_ENABLE]; // [RULE16]
        end
        st_nxt.flush = wr_fc && !wdata[FC_ENABLE]; // [RULE16]
        loop_nxt = st_nxt.mc[MC_LOOP];

        // Holding empty source depends on mode
        st_nxt.txf_empty_q = tx_fifo_empty;
        if (st_r.fifo_en) begin
            hold_set = tx_fifo_empty && !st_r.txf_empty_q; // [RULE15]
        end else begin
            hold_set = tx_load; // [RULE13]
        end
        // Set wins over a write in the same cycle
        if (hold_set) begin
            st_nxt.hold_empty = 1'b1; // [RULE13] [RULE15]
        end else if (tx_write) begin
            st_nxt.hold_empty = 1'b0; // [RULE15]
        end
        st_nxt.temt = st_nxt.hold_empty && tx_shift_empty; // [RULE12]

        if (hold_set) begin
            st_nxt.hold_pend = 1'b1; // [RULE14]
        end else if (rd_ident) begin
            st_nxt.hold_pend = 1'b0; // [RULE14]
        end

        // Error summary; a new errored char beats the clearing read
        if (!st_nxt.fifo_en) begin
            st_nxt.rx_err = 1'b0; // [RULE9]
        end else if (rx_err_push) begin
            st_nxt.rx_err = 1'b1; // [RULE10]
        end else if (rd_ls && !rx_err_remain) begin
            st_nxt.rx_err = 1'b0; // [RULE11]
        end

        ev = '0;
        ev[EV_HOLD_EMPTY] = hold_set;
        ev[EV_RX_ERR] = rx_err_push && st_nxt.fifo_en;
        if (wr_sts) begin
            st_nxt.sts = (st_r.sts & ~wdata[1:0]) | ev;
        end else begin
            st_nxt.sts = st_r.sts | ev;
        end
        if (wr_msk) begin
            st_nxt.msk = wdata[1:0];
        end

        // Pins and modem status
        if (loop_nxt) begin
            st_nxt.tx_pin = 1'b1; // [RULE1]
            st_nxt.rx_in = tx_shift_out; // [RULE2]
            st_nxt.dtr_n = 1'b1; // [RULE4]
            st_nxt.rts_n = 1'b1; // [RULE4]
            st_nxt.msl = {st_nxt.mc[MC_AUX_B], st_nxt.mc[MC_AUX_A],
                          st_nxt.mc[MC_DTR], st_nxt.mc[MC_RTS]}; // [RULE3] [RULE17]
        end else begin
            st_nxt.tx_pin = tx_shift_out;
            st_nxt.rx_in = pins_s[0];
            st_nxt.dtr_n = !st_nxt.mc[MC_DTR]; // [RULE8]
            st_nxt.rts_n = !st_nxt.mc[MC_RTS]; // [RULE7]
            st_nxt.msl = ~pins_s[4:1];
        end

        // Whole serial interrupt is gated by aux out b
        st_nxt.irq = st_nxt.mc[MC_AUX_B] && (port_irq_in || st_nxt.hold_pend
                     || |(st_nxt.sts & st_nxt.msk)); // [RULE5]

        st_nxt.rdata = 8'h00;
        if (rd) begin
            unique case (addr)
                OFS_MODEM_CONTROL: st_nxt.rdata = {3'h0, st_r.mc}; // [RULE18]
                OFS_LINE_STATUS: st_nxt.rdata = {st_r.rx_err, st_r.temt,
                                                 st_r.hold_empty, ls_low};
                OFS_FIFO_IDENT: st_nxt.rdata = {{2{st_r.fifo_en}}, 3'h0,
                                                st_r.hold_pend ? IDENT_HOLD_EMPTY : IDENT_NONE};
                OFS_IRQ_STATUS: st_nxt.rdata = {6'h00, st_r.sts};
                OFS_IRQ_MASK: st_nxt.rdata = {6'h00, st_r.msk};
                default: st_nxt.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            st_r.mc <= MC_RESET;
            st_r.fifo_en <= 1'b0;
            st_r.rx_err <= LS_RX_ERR_RESET;
            st_r.temt <= LS_TEMT_RESET;
            st_r.hold_empty <= LS_HOLD_EMPTY_RESET;
            st_r.hold_pend <= 1'b0;
            st_r.txf_empty_q <= 1'b1;
            st_r.sts <= IRQ_STS_RESET;
            st_r.msk <= IRQ_MSK_RESET;
            st_r.rdata <= 8'h00;
            st_r.tx_pin <= 1'b1;
            st_r.rx_in <= 1'b1;
            st_r.dtr_n <= 1'b1;
            st_r.rts_n <= 1'b1;
            st_r.msl <= 4'h0;
            st_r.irq <= 1'b0;
            st_r.flush <= 1'b0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign rdata = st_r.rdata;
    assign serial_tx_pin = st_r.tx_pin;
    assign rts_n = st_r.rts_n;
    assign dtr_n = st_r.dtr_n;
    assign rx_serial_in = st_r.rx_in;
    assign modem_status = st_r.msl;
    assign fifo_mode = st_r.fifo_en;
    assign fifo_flush = st_r.flush;
    assign hold_empty_irq = st_r.hold_pend;
    assign irq = st_r.irq;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    sequence s_mc_write_loop;
        wr && (addr == OFS_MODEM_CONTROL) && wdata[MC_LOOP];
    endsequence

    sequence s_ident_clear;
        rd && (addr == OFS_FIFO_IDENT) && !hold_set;
    endsequence

    chk_loop_tx_mark: assert property ( // [RULE1]
        s_mc_write_loop |=> serial_tx_pin [*2])
        else $error("transmit pin not marking in loopback");

    chk_loop_rx_path: assert property ( // [RULE2]
        st_nxt.mc[MC_LOOP] |=> rx_serial_in == $past(tx_shift_out))
        else $error("loopback receive path broken");

    chk_loop_modem_in: assert property ( // [RULE17]
        st_nxt.mc[MC_LOOP] |=> modem_status == {st_r.mc[MC_AUX_B],
            st_r.mc[MC_AUX_A], st_r.mc[MC_DTR], st_r.mc[MC_RTS]})
        else $error("loopback modem status wrong");

    chk_loop_pins_high: assert property ( // [RULE4]
        st_r.mc[MC_LOOP] |-> dtr_n && rts_n)
        else $error("modem pins not high in loopback");

    chk_irq_gate: assert property ( // [RULE5]
        !st_r.mc[MC_AUX_B] |-> !irq)
        else $error("interrupt passed while gate off");

    chk_rts_invert: assert property ( // [RULE7]
        !st_r.mc[MC_LOOP] |-> rts_n == !st_r.mc[MC_RTS])
        else $error("request-to-send not inverse");

    chk_dtr_invert: assert property ( // [RULE8]
        !st_r.mc[MC_LOOP] |-> dtr_n == !st_r.mc[MC_DTR])
        else $error("terminal-ready not inverse");

    chk_rxerr_nofifo: assert property ( // [RULE9]
        !fifo_mode |-> !st_r.rx_err)
        else $error("fifo error set without fifos");

    chk_temt_both: assert property ( // [RULE12]
        st_r.temt |-> st_r.hold_empty)
        else $error("transmitter empty with holding full");

    chk_hold_raise: assert property ( // [RULE14]
        hold_set |=> hold_empty_irq)
        else $error("transmit interrupt not raised");

    chk_hold_clear: assert property ( // [RULE14]
        s_ident_clear |=> !hold_empty_irq)
        else $error("transmit interrupt not cleared by ident read");

    chk_hold_load: assert property ( // [RULE13]
        (!fifo_mode && tx_load) |=> st_r.hold_empty)
        else $error("holding empty not set on load");

    chk_hold_fifo_wr: assert property ( // [RULE15]
        (fifo_mode && tx_write && !hold_set) |=> !st_r.hold_empty)
        else $error("holding empty not cleared by fifo write");

    chk_temt_exact: assert property ( // [RULE12]
        1'b1 |=> st_r.temt == (st_r.hold_empty && $past(tx_shift_empty)))
        else $error("transmitter empty does not follow both registers");

    chk_rxerr_set: assert property ( // [RULE10]
        (fifo_mode && rx_err_push && !wr_fc) |=> st_r.rx_err)
        else $error("fifo error not set by errored char");

    chk_rxerr_keep: assert property ( // [RULE11]
        (st_r.rx_err && rd_ls && rx_err_remain && !wr_fc) |=> st_r.rx_err)
        else $error("fifo error cleared while errors remain");

    chk_rxerr_clear: assert property ( // [RULE11]
        (rd_ls && !rx_err_remain && !rx_err_push) |=> !st_r.rx_err)
        else $error("fifo error not cleared by status read");

    chk_flush_pulse: assert property ( // [RULE16]
        (wr_fc && !wdata[FC_ENABLE]) |=> fifo_flush && !fifo_mode)
        else $error("fifo disable did not flush");

    chk_irq_pass: assert property ( // [RULE5]
        (st_nxt.mc[MC_AUX_B] && port_irq_in) |=> irq)
        else $error("interrupt blocked while gate on");

    chk_mc_reserved: assert property ( // [RULE18]
        (rd && addr == OFS_MODEM_CONTROL) |=> rdata[7:5] == 3'h0)
        else $error("reserved modem control bits nonzero");

endmodule : umcls_top
`default_nettype wire

// ===== umcls_modem_model.sv
// Far-end modem model: drives the four handshake pins and the receive line.
// Assumes the bench commands the true levels the modem should present.
`timescale 1ns/1ps
`default_nettype none
module umcls_modem_model (
    input wire logic ref_clk,           // Time base shared with the host
    input wire logic slow,              // Adds one cycle of lag to every change
    input wire logic [3:0] want,        // {carrier, ring, dsr, cts} true levels
    input wire logic rx_level,          // Line level sent towards the host
    output logic cts_n,                 // Clear-to-send pin
    output logic dsr_n,                 // Data-set-ready pin
    output logic ring_indicator_n,      // Ring pin
    output logic carrier_detect_n,      // Carrier detect pin
    output logic serial_rx_pin          // Host receive pin
);
    logic [4:0] stage_r;
    logic [4:0] out_r;

    // Pins are active low, so the model inverts the wanted levels
    always_ff @(posedge ref_clk) begin
        stage_r <= {rx_level, ~want};
        out_r <= slow ? stage_r : {rx_level, ~want};
    end

    assign {serial_rx_pin, carrier_detect_n, ring_indicator_n, dsr_n, cts_n} = out_r;
endmodule : umcls_modem_model
`default_nettype wire

// ===== tb.sv
// Self-checking bench for the modem-control and line-status block.
// Assumes the modem model beside it and a 125 MHz ref_clk.
`timescale 1ns/1ps
`default_nettype none
module tb
    import umcls_pkg::*;
;
    logic ref_clk, reset, wr, rd, tx_shift_out, tx_shift_empty, tx_load, tx_write;
    logic tx_fifo_empty, rx_err_push, rx_err_remain, port_irq_in, slow, rx_level;
    logic serial_rx_pin, cts_n, dsr_n, ring_indicator_n, carrier_detect_n;
    logic serial_tx_pin, rts_n, dtr_n;
    logic rx_serial_in, fifo_mode, fifo_flush, hold_empty_irq, irq;
    logic [ADDR_W-1:0] addr;
    logic [7:0] wdata, rdata, v, r, s;
    logic [4:0] ls_low;
    logic [3:0] want, modem_status;
    logic [31:0] lfsr_r;
    int fail_count;
    int n_checks;

    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    umcls_top umcls_top_inst (.ref_clk(ref_clk), .reset(reset), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .tx_shift_out(tx_shift_out),
        .tx_shift_empty(tx_shift_empty), .tx_load(tx_load), .tx_write(tx_write),
        .tx_fifo_empty(tx_fifo_empty), .rx_err_push(rx_err_push),
        .rx_err_remain(rx_err_remain), .ls_low(ls_low), .port_irq_in(port_irq_in),
        .serial_rx_pin(serial_rx_pin), .cts_n(cts_n), .dsr_n(dsr_n),
        .ring_indicator_n(ring_indicator_n), .carrier_detect_n(carrier_detect_n),
        .serial_tx_pin(serial_tx_pin),
        .rts_n(rts_n), .dtr_n(dtr_n), .rx_serial_in(rx_serial_in),
        .modem_status(modem_status), .fifo_mode(fifo_mode), .fifo_flush(fifo_flush),
        .hold_empty_irq(hold_empty_irq), .irq(irq));

    umcls_modem_model umcls_modem_model_inst (.ref_clk(ref_clk), .slow(slow), .want(want),
        .rx_level(rx_level), .cts_n(cts_n), .dsr_n(dsr_n),
        .ring_indicator_n(ring_indicator_n), .carrier_detect_n(carrier_detect_n),
        .serial_rx_pin(serial_rx_pin));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] lfsr_step(input logic [31:0] st);
        return {st[30:0], st[31] ^ st[21] ^ st[1] ^ st[0]};
    endfunction : lfsr_step

    task automatic check(input string name, input logic [7:0] exp, input logic [7:0] seen);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : tick

    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge ref_clk);
        wr <= 1'b0;
    endtask : wr_reg

    // Read data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [3:0] a);
        @(posedge ref_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge ref_clk);
        rd <= 1'b0;
        #1;
        r = rdata;
    endtask : rd_reg

    // Bits: 2 errored char pushed, 1 byte written, 0 char moved to shift register
    task automatic strobe(input logic [2:0] sel);
        @(posedge ref_clk);
        {rx_err_push, tx_write, tx_load} <= sel;
        @(posedge ref_clk);
        {rx_err_push, tx_write, tx_load} <= 3'h0;
    endtask : strobe

    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : summarize

    initial begin
        #200000;
        fail_count++;
        $display("watchdog expired");
        summarize();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        {reset, tx_shift_empty, tx_fifo_empty, rx_level} = 4'hF;
        {wr, rd, tx_shift_out, tx_load, tx_write, rx_err_push, rx_err_remain} = 7'h10;
        {port_irq_in, slow, want, ls_low, addr, wdata} = 23'h0;
        lfsr_r = 32'h0001_3682;
        fail_count = 0;
        n_checks = 0;
        repeat (12) @(posedge ref_clk);
        reset <= 1'b0;
        rd_reg(OFS_MODEM_CONTROL);
        check("modem_control reset", 8'h00, r);
        rd_reg(OFS_LINE_STATUS);
        check("line_status reset", 8'h60, r);
        check("pins reset", 8'h07, {5'h0, serial_tx_pin, rts_n, dtr_n});
        check("flags reset", 8'h01, {4'h0, fifo_mode, hold_empty_irq, irq, rx_serial_in});
        $display("end of test reset");

        for (int i = 0; i < 16; i++) begin
            lfsr_r = lfsr_step(lfsr_r);
            v = (i < 2) ? {4'hE, i[0], 3'h7} : lfsr_r[7:0];
            s = lfsr_r[15:8];
            @(posedge ref_clk);
            {want, tx_shift_out, slow, port_irq_in} <= s[6:0];
            rx_level <= ~s[2];
            ls_low <= lfsr_r[20:16];
            wr_reg(OFS_MODEM_CONTROL, v);
            tick(6);
            check("irq gate", {7'h0, v[3] & s[0]}, {7'h0, irq});
            if (v[4]) begin
                check("loop pins", 8'h07, {5'h0, serial_tx_pin, rts_n, dtr_n});
                check("loop status", {4'h0, v[3:2], v[0], v[1]}, {4'h0, modem_status});
                check("loop rx", {7'h0, s[2]}, {7'h0, rx_serial_in});
            end else begin
                check("pins", {5'h0, s[2], ~v[1], ~v[0]}, {5'h0, serial_tx_pin, rts_n, dtr_n});
                check("status", {4'h0, s[6:3]}, {4'h0, modem_status});
                check("rx", {7'h0, ~s[2]}, {7'h0, rx_serial_in});
            end
            rd_reg(OFS_MODEM_CONTROL);
            check("modem_control", {3'h0, v[4:0]}, r);
        end
        $display("end of test modem control");

        port_irq_in <= 1'b0;
        tx_shift_empty <= 1'b0;
        wr_reg(OFS_MODEM_CONTROL, 8'h08);
        strobe(3'b010);
        strobe(3'b001);
        tick(2);
        check("hold_empty_irq", 8'h01, {7'h0, hold_empty_irq});
        check("irq", 8'h01, {7'h0, irq});
        rd_reg(OFS_LINE_STATUS);
        check("line_status loaded", {3'b001, ls_low}, r);
        tx_shift_empty <= 1'b1;
        tick(2);
        rd_reg(OFS_LINE_STATUS);
        check("line_status empty", {3'b011, ls_low}, r);
        rd_reg(OFS_FIFO_IDENT);
        check("ident hold empty", {5'h0, IDENT_HOLD_EMPTY}, r);
        tick(1);
        check("hold_empty_irq cleared", 8'h00, {7'h0, hold_empty_irq});
        rd_reg(OFS_FIFO_IDENT);
        check("ident none", {5'h0, IDENT_NONE}, r);
        rd_reg(OFS_IRQ_STATUS);
        check("irq status", 8'h01, r);
        tick(2);
        check("irq masked", 8'h00, {7'h0, irq});
        wr_reg(OFS_IRQ_MASK, 8'h01);
        tick(2);
        check("irq unmasked", 8'h01, {7'h0, irq});
        wr_reg(OFS_IRQ_STATUS, 8'h01);
        tick(2);
        check("irq cleared", 8'h00, {7'h0, irq});
        rd_reg(4'hF);
        check("unmapped", 8'h00, r);
        $display("end of test holding empty");

        wr_reg(OFS_FIFO_IDENT, 8'h01);
        tx_fifo_empty <= 1'b0;
        tick(2);
        check("fifo_mode on", 8'h01, {7'h0, fifo_mode});
        strobe(3'b010);
        rd_reg(OFS_LINE_STATUS);
        check("hold empty cleared", {3'b000, ls_low}, r);
        tx_fifo_empty <= 1'b1;
        tick(2);
        rd_reg(OFS_LINE_STATUS);
        check("hold empty fifo", {3'b011, ls_low}, r);
        rd_reg(OFS_FIFO_IDENT);
        check("ident fifo", {5'h18, IDENT_HOLD_EMPTY}, r);
        rx_err_remain <= 1'b1;
        strobe(3'b100);
        for (int k = 0; k < 4; k++) begin
            if (k == 1) begin
                rx_err_remain <= 1'b0;
            end
            rd_reg(OFS_LINE_STATUS);
            check("rx fifo err", {7'h0, k < 2}, {7'h0, r[7]});
        end
        rd_reg(OFS_IRQ_STATUS);
        check("irq status fifo", 8'h03, r);
        wr_reg(OFS_IRQ_STATUS, 8'h03);
        // Leave an error pending so the disable has something to clear
        strobe(3'b100);
        wr_reg(OFS_FIFO_IDENT, 8'h00);
        #1;
        check("flush pulse", 8'h01, {7'h0, fifo_flush});
        tick(1);
        check("fifo off", 8'h00, {6'h0, fifo_mode, fifo_flush});
        strobe(3'b100);
        rd_reg(OFS_LINE_STATUS);
        check("rx err non-fifo", 8'h00, {7'h0, r[7]});
        $display("end of test fifo mode");
        summarize();
    end
endmodule : tb
`default_nettype wire
